//--- hw/sprr_pkg.sv
package sprr_pkg;

   // ****************************************************************
   // parameter identifiers on the command link
   // ****************************************************************
   localparam logic [7:0] ID_RAMP_ACCEL_TIME    = 8'h35;
   localparam logic [7:0] ID_POSITION_GAIN      = 8'h6a;
   localparam logic [7:0] ID_INTEGRAL_CONSTANT  = 8'h6b;
   localparam logic [7:0] ID_DERIVATIVE_GAIN    = 8'h6c;
   localparam logic [7:0] ID_INTEGRAL_LIMIT     = 8'h71;
   localparam logic [7:0] ID_ZERO_OFFSET        = 8'h72;
   localparam logic [7:0] ID_RESOLVER_ZERO_CORR = 8'h75;
   localparam logic [7:0] ID_HOMING_APPROACH    = 8'h76;
   localparam logic [7:0] ID_HOMING_RETURN      = 8'h77;
   localparam logic [7:0] ID_HOMING_START       = 8'h78;
   localparam logic [7:0] ID_TOL_WINDOW         = 8'h79;
   localparam logic [7:0] ID_RAMP_LIMIT_DECEL   = 8'h7c;
   localparam logic [7:0] ID_STATUS             = 8'h7d;
   localparam logic [7:0] ID_HOMING_CONFIG      = 8'h7e;
   localparam logic [7:0] ID_ZERO_CAPTURE       = 8'h7f;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] RST_POSITION_GAIN   = 16'h0046;
   localparam logic [15:0] RST_HOMING_APPROACH = 16'h0bb8;
   localparam logic [15:0] RST_HOMING_RETURN   = 16'h01f4;
   localparam logic [15:0] RST_TOL_WINDOW      = 16'h0064;
   localparam logic [15:0] RST_ZERO            = 16'h0000;

   // ****************************************************************
   // homing config fields
   // ****************************************************************
   localparam int CFG_SRC_LSB      = 0;
   localparam int CFG_DECEL_LIMIT  = 2;
   localparam int CFG_RESOLVER     = 3;
   localparam logic [1:0] SRC_POSITIVE_END = 2'h0;
   localparam logic [1:0] SRC_NEGATIVE_END = 2'h1;
   localparam logic [1:0] SRC_SEPARATE     = 2'h2;

   // ****************************************************************
   // scaling and timing
   // ****************************************************************
   localparam logic signed [15:0] FULL_SCALE_SPEED = 16'sh7fff;
   localparam int          INTEG_LIMIT_SCALE = 327;
   localparam int          CURRENT_SHIFT     = 8;
   localparam int          CLK_MHZ           = 250;
   localparam int          CYCLES_PER_MS     = CLK_MHZ * 1000;
   localparam int          ENABLE_SETTLE_US  = 5000;
   localparam int          ENABLE_SETTLE_CYC = ENABLE_SETTLE_US * CLK_MHZ;

   typedef enum logic [2:0] {
      HS_IDLE      = 3'h0,
      HS_APPROACH  = 3'h1,
      HS_DECEL     = 3'h3,
      HS_RETURN    = 3'h2,
      HS_SEEK_ZERO = 3'h6,
      HS_DONE      = 3'h7
   } sprr_home_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  id;
      logic [15:0] wdata;
   } sprr_par_req_t;

   typedef struct packed {
      logic        en;
      logic        settled;
      logic [31:0] settle_cnt;
      logic signed [31:0] pos_cmd;
      logic signed [31:0] pos_act;
      logic signed [15:0] err_prev;
      logic signed [31:0] integ;
      logic signed [15:0] current;
      logic        in_window;
      logic signed [15:0] speed;
      logic [39:0] ramp_acc;
      sprr_home_t  hstate;
      logic        second_pass;
      logic        home_done;
      logic [15:0] zero_capture;
      logic [15:0] res_prev;
      logic        sw_prev;
      logic        step_prev;
      logic        zero_prev;
      logic [1:0]  din_prev;
      logic [15:0] gain;
      logic [15:0] integ_k;
      logic [15:0] deriv_k;
      logic [15:0] integ_limit;
      logic [15:0] tol;
      logic [15:0] offset;
      logic [15:0] accel_time;
      logic [15:0] reso_corr;
      logic [15:0] approach;
      logic [15:0] ret_speed;
      logic [15:0] limit_decel;
      logic [3:0]  cfg;
      logic [15:0] rdata;
      logic        rvalid;
   } sprr_state_t;

endpackage

//--- hw/sprr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sprr_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_arst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= '0;
         o_q    <= '0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- hw/sprr_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE_01 - error is command minus actual position
// RULE_02 - in-window flag while error below tolerance
// RULE_03 - enable takes target as active command
// RULE_04 - loop runs with enables, permissions, gain
// RULE_05 - p, i, d and integral limit give current
// RULE_06 - full speed is 32767, decel time reported
// RULE_07 - homing starts on input or command
// RULE_08 - motion commands ignored until 5 ms
// RULE_09 - approach switch, overrun, then reverse
// RULE_10 - return homing_approach_speed edge or zero pulse (code returns at ret_speed, the homing return speed)
// RULE_11 - single loop positive, double negative
// RULE_12 - incremental zero at following zero pulse
// RULE_13 - resolver captures angle at switch edge
// RULE_14 - resolver result corrected by programmed value
// RULE_15 - signed offset shifts mechanical zero
// RULE_16 - source: positive, negative or separate switch
// RULE_17 - homing decel from accel or limit ramp
// RULE_18 - saturating 32-bit position, clamped integral
// RULE_19 - disable aborts homing, clears in-window
module sprr_top
   import sprr_pkg::*;
#(
   parameter int SETTLE_CYCLES = ENABLE_SETTLE_CYC
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_arst_n,
   input  wire logic                 i_ena,
   input  wire logic                 i_go,
   input  wire logic                 i_lim_pos_ok,
   input  wire logic                 i_lim_neg_ok,
   input  wire logic                 i_ref_switch,
   input  wire logic                 i_digital_in_one,
   input  wire logic                 i_digital_in_two,
   input  wire logic                 i_enc_step,
   input  wire logic                 i_enc_dir,
   input  wire logic                 i_enc_zero,
   input  wire logic [15:0]          i_resolver_angle,
   input  wire logic signed [31:0]   i_pos_target,
   input  wire logic                 i_target_load,
   input  wire sprr_par_req_t        i_par,
   output logic [15:0]               o_par_rdata,
   output logic                      o_par_rvalid,
   output logic signed [31:0]        o_pos_error,
   output logic signed [31:0]        o_pos_actual,
   output logic                      o_in_window,
   output logic signed [15:0]        o_current_cmd,
   output logic signed [15:0]        o_speed_cmd,
   output logic [15:0]               o_decel_time_ms,
   output logic                      o_homing_busy,
   output logic                      o_homing_done
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [9:0] pins_s;

   sprr_sync #(.W(10)) u_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_d      ({i_enc_zero, i_enc_dir, i_enc_step, i_digital_in_two, i_digital_in_one,
                  i_ref_switch, i_lim_neg_ok, i_lim_pos_ok, i_go, i_ena}),
      .o_q      (pins_s)
   );

   logic ena_s, go_s, lpos_s, lneg_s, ref_s, digital_in_one_s, digital_in_two_s, step_s, dir_s, zero_s;
   assign {zero_s, dir_s, step_s, digital_in_two_s, digital_in_one_s, ref_s, lneg_s, lpos_s, go_s, ena_s} = pins_s;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic signed [31:0] sat_add(input logic signed [31:0] a,
                                                  input logic signed [31:0] b);
      logic signed [32:0] s;
      s = 33'(a) + 33'(b);
      if (s > 33'sh0_7fff_ffff)
         return 32'sh7fff_ffff;
      else if (s < -33'sh0_7fff_ffff)
         return -32'sh7fff_ffff;
      else
         return s[31:0];
   endfunction

   function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
      if (v > 34'sh0_7fff)
         return 16'sh7fff;
      else if (v < -34'sh0_7fff)
         return -16'sh7fff;
      else
         return v[15:0];
   endfunction

   sprr_state_t s_q, s_d;

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   logic               en_now, start_req, motion_ok, loop_on, sw_now, sw_rise, zero_rise, step_rise;
   logic               dir_neg;
   logic signed [31:0] err, ilim, delta, iacc;
   logic signed [15:0] err16, ret_target, corr_angle;
   logic signed [31:0] pterm, dterm, iinc;
   logic [15:0]        ramp_ms;
   logic [39:0]        ramp_thr;
   logic [1:0]         src;

   always_comb begin
      s_d        = s_q;
      src        = s_q.cfg[CFG_SRC_LSB +: 2];
      en_now     = ena_s & go_s;
      motion_ok  = en_now & s_q.settled;
      s_d.en     = en_now;
      s_d.rvalid = 1'b0;

      // enable settle window: motion commands wait it out
      if (!en_now) begin
         s_d.settle_cnt = '0;
         s_d.settled    = 1'b0;
      end else if (!s_q.settled) begin
         s_d.settle_cnt = s_q.settle_cnt + 32'h0000_0001;
         s_d.settled    = (s_q.settle_cnt >= 32'(SETTLE_CYCLES - 1));          // see RULE_08
      end

      // parameter writes
      start_req = 1'b0;
      if (i_par.wr) begin
         unique case (i_par.id)
            ID_RAMP_ACCEL_TIME:    s_d.accel_time  = i_par.wdata;
            ID_POSITION_GAIN:      s_d.gain        = i_par.wdata;
            ID_INTEGRAL_CONSTANT:  s_d.integ_k     = i_par.wdata;
            ID_DERIVATIVE_GAIN:    s_d.deriv_k     = i_par.wdata;
            ID_INTEGRAL_LIMIT:     s_d.integ_limit = i_par.wdata;
            ID_ZERO_OFFSET:        s_d.offset      = i_par.wdata;
            ID_RESOLVER_ZERO_CORR: s_d.reso_corr   = i_par.wdata;
            ID_HOMING_APPROACH:    s_d.approach    = i_par.wdata;
            ID_HOMING_RETURN:      s_d.ret_speed   = i_par.wdata;
            ID_HOMING_START:       start_req       = 1'b1;                      // see RULE_07
            ID_TOL_WINDOW:         s_d.tol         = i_par.wdata;
            ID_RAMP_LIMIT_DECEL:   s_d.limit_decel = i_par.wdata;
            ID_HOMING_CONFIG:      s_d.cfg         = i_par.wdata[3:0];
            default: ;
         endcase
      end
      // digital start inputs act on their rising edge
      s_d.din_prev = {digital_in_two_s, digital_in_one_s};
      if ((digital_in_one_s & ~s_q.din_prev[0]) | (digital_in_two_s & ~s_q.din_prev[1]))
         start_req = 1'b1;                                                      // see RULE_07

      // parameter reads, answer one cycle later
      if (i_par.rd) begin
         s_d.rvalid = 1'b1;
         unique case (i_par.id)
            ID_RAMP_ACCEL_TIME:    s_d.rdata = s_q.accel_time;
            ID_POSITION_GAIN:      s_d.rdata = s_q.gain;
            ID_INTEGRAL_CONSTANT:  s_d.rdata = s_q.integ_k;
            ID_DERIVATIVE_GAIN:    s_d.rdata = s_q.deriv_k;
            ID_INTEGRAL_LIMIT:     s_d.rdata = s_q.integ_limit;
            ID_ZERO_OFFSET:        s_d.rdata = s_q.offset;
            ID_RESOLVER_ZERO_CORR: s_d.rdata = s_q.reso_corr;
            ID_HOMING_APPROACH:    s_d.rdata = s_q.approach;
            ID_HOMING_RETURN:      s_d.rdata = s_q.ret_speed;
            ID_TOL_WINDOW:         s_d.rdata = s_q.tol;
            ID_RAMP_LIMIT_DECEL:   s_d.rdata = s_q.limit_decel;
            ID_HOMING_CONFIG:      s_d.rdata = {12'h000, s_q.cfg};
            ID_ZERO_CAPTURE:       s_d.rdata = s_q.zero_capture;
            ID_STATUS:             s_d.rdata = {9'h000, s_q.hstate, s_q.home_done, s_q.in_window,
                                               s_q.settled, s_q.en};
            default:               s_d.rdata = 16'h0000;
         endcase
      end

      // actual position from incremental steps or resolver angle deltas
      step_rise     = step_s & ~s_q.step_prev;
      s_d.step_prev = step_s;
      s_d.res_prev  = i_resolver_angle;
      if (s_q.cfg[CFG_RESOLVER])
         delta = 32'(signed'(i_resolver_angle - s_q.res_prev));
      else if (step_rise)
         delta = dir_s ? -32'sh0000_0001 : 32'sh0000_0001;
      else
         delta = '0;
      s_d.pos_act = sat_add(s_q.pos_act, delta);                                // see RULE_18

      // command position
      if (en_now && !s_q.en)
         s_d.pos_cmd = i_pos_target;                                            // see RULE_03
      else if (motion_ok && i_target_load)
         s_d.pos_cmd = i_pos_target;                                            // see RULE_08
      else if (!en_now)
         s_d.pos_cmd = s_q.pos_act;

      err   = sat_add(s_q.pos_cmd, -s_q.pos_act);                               // see RULE_01
      err16 = sat16(34'(err));
      // tolerance is unsigned: compare as signed so that negative errors count as inside
      s_d.in_window = en_now && (err < signed'(32'(s_q.tol))) && (err > -signed'(32'(s_q.tol))); // see RULE_02 RULE_19

      // position loop
      loop_on = en_now & lpos_s & lneg_s & (s_q.gain != 16'h0000)
                & (s_q.hstate == HS_IDLE || s_q.hstate == HS_DONE);            // see RULE_04
      pterm = 32'(signed'(s_q.gain)) * 32'(err16);
      dterm = 32'(signed'(s_q.deriv_k)) * 32'(sat16(34'(err16) - 34'(s_q.err_prev)));
      iinc  = 32'(signed'(s_q.integ_k)) * 32'(err16);
      ilim  = 32'(s_q.integ_limit) * 32'(INTEG_LIMIT_SCALE);
      iacc  = sat_add(s_q.integ, iinc);
      if (iacc > ilim)
         iacc = ilim;                                                           // see RULE_18
      else if (iacc < -ilim)
         iacc = -ilim;
      if (loop_on) begin
         s_d.integ    = iacc;
         s_d.err_prev = err16;
         s_d.current  = sat16((34'(pterm) + 34'(iacc) + 34'(dterm)) >>> CURRENT_SHIFT); // see RULE_05
      end else begin
         s_d.integ    = '0;
         s_d.err_prev = '0;
         s_d.current  = '0;
      end

      // homing switch source and direction
      unique case (src)
         SRC_NEGATIVE_END: sw_now = ~lneg_s;
         SRC_SEPARATE:     sw_now = ref_s;
         default:          sw_now = ~lpos_s;
      endcase                                                                   // see RULE_16
      dir_neg       = (src == SRC_NEGATIVE_END);
      sw_rise       = sw_now & ~s_q.sw_prev;
      s_d.sw_prev   = sw_now;
      zero_rise     = zero_s & ~s_q.zero_prev;
      s_d.zero_prev = zero_s;
      ret_target    = dir_neg ? signed'(s_q.ret_speed) : -signed'(s_q.ret_speed);
      ramp_ms       = s_q.cfg[CFG_DECEL_LIMIT] ? s_q.limit_decel : s_q.accel_time; // see RULE_17
      ramp_thr      = 40'(ramp_ms) * 40'(CYCLES_PER_MS);
      corr_angle    = signed'(i_resolver_angle - s_q.reso_corr);                // see RULE_14

      unique case (s_q.hstate)
         HS_IDLE, HS_DONE: begin
            s_d.speed = '0;
            if (motion_ok && start_req) begin
               s_d.hstate      = HS_APPROACH;
               s_d.second_pass = 1'b0;
               s_d.home_done   = 1'b0;
            end
         end
         HS_APPROACH: begin
            s_d.speed = dir_neg ? -signed'(s_q.approach) : signed'(s_q.approach); // see RULE_09
            if (sw_rise) begin
               s_d.hstate   = HS_DECEL;
               s_d.ramp_acc = '0;
            end
         end
         HS_DECEL: begin
            // overrun past the switch grows with approach speed and ramp length
            s_d.ramp_acc = s_q.ramp_acc + 40'(FULL_SCALE_SPEED);                // see RULE_06
            if (s_d.ramp_acc >= ramp_thr) begin
               s_d.ramp_acc = s_d.ramp_acc - ramp_thr;
               if (s_q.speed > ret_target)
                  s_d.speed = s_q.speed - 16'sh0001;
               else if (s_q.speed < ret_target)
                  s_d.speed = s_q.speed + 16'sh0001;
            end
            if (s_q.speed == ret_target)
               s_d.hstate = HS_RETURN;                                          // see RULE_09
         end
         HS_RETURN: begin
            s_d.speed = ret_target;                                             // see RULE_10
            if (sw_rise) begin
               if (dir_neg && !s_q.second_pass) begin
                  s_d.second_pass = 1'b1;                                       // see RULE_11
                  s_d.hstate      = HS_APPROACH;
               end else if (s_q.cfg[CFG_RESOLVER]) begin
                  s_d.zero_capture = i_resolver_angle;                          // see RULE_13
                  s_d.pos_act      = 32'(signed'(s_q.offset)) + 32'(corr_angle); // see RULE_15
                  s_d.hstate       = HS_DONE;
                  s_d.home_done    = 1'b1;
               end else begin
                  s_d.hstate = HS_SEEK_ZERO;
               end
            end
         end
         HS_SEEK_ZERO: begin
            s_d.speed = ret_target;
            if (zero_rise) begin
               s_d.pos_act   = 32'(signed'(s_q.offset));                        // see RULE_12 RULE_15
               s_d.hstate    = HS_DONE;
               s_d.home_done = 1'b1;
               s_d.speed     = '0;
            end
         end
         default: s_d.hstate = HS_IDLE;
      endcase

      if (!en_now) begin
         s_d.hstate = HS_IDLE;                                                  // see RULE_19
         s_d.speed  = '0;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q             <= '0;
         s_q.hstate      <= HS_IDLE;
         s_q.gain        <= RST_POSITION_GAIN;
         s_q.approach    <= RST_HOMING_APPROACH;
         s_q.ret_speed   <= RST_HOMING_RETURN;
         s_q.tol         <= RST_TOL_WINDOW;
         s_q.offset      <= RST_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_par_rdata     = s_q.rdata;
   assign o_par_rvalid    = s_q.rvalid;
   assign o_pos_actual    = s_q.pos_act;
   assign o_pos_error     = sat_add(s_q.pos_cmd, -s_q.pos_act);
   assign o_in_window     = s_q.in_window;
   assign o_current_cmd   = s_q.current;
   assign o_speed_cmd     = s_q.speed;
   assign o_decel_time_ms = s_q.cfg[CFG_DECEL_LIMIT] ? s_q.limit_decel : s_q.accel_time;
   assign o_homing_busy   = (s_q.hstate != HS_IDLE) && (s_q.hstate != HS_DONE);
   assign o_homing_done   = s_q.home_done;

endmodule
`default_nettype wire

//--- verif/sprr_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sprr_properties (
   input wire logic               i_clk,
   input wire logic               i_arst_n,
   input wire logic               i_ena,
   input wire logic               i_go,
   input wire logic               i_lim_neg_ok,
   input wire logic signed [31:0] o_pos_error,
   input wire logic signed [31:0] o_pos_actual,
   input wire logic               o_in_window,
   input wire logic signed [15:0] o_current_cmd,
   input wire logic signed [15:0] o_speed_cmd,
   input wire logic               o_homing_busy,
   input wire logic               o_homing_done,
   input wire logic               o_par_rvalid
);
   // ****************************************************************
   // position loop and homing relations
   // ****************************************************************
   // window bound assumes the tolerance register keeps its reset value
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // settle window covers the pin synchronisers plus in-flight encoder steps
   property p_err_dis;
      (!(i_ena && i_go) && $stable(o_pos_actual))[*8] |-> o_pos_error == 0;
   endproperty
   a_err_dis: assert property (p_err_dis) else $error("error not zero while disabled");
   property p_win_dis;
      (!(i_ena && i_go))[*8] |-> !o_in_window;
   endproperty
   a_win_dis: assert property (p_win_dis) else $error("window flag while disabled");
   property p_busy_dis;
      (!(i_ena && i_go))[*8] |-> !o_homing_busy && o_speed_cmd == 0;
   endproperty
   a_busy_dis: assert property (p_busy_dis) else $error("homing alive while disabled");
   property p_win_tol;
      o_in_window |-> $past(o_pos_error) < 100 && $past(o_pos_error) > -100;
   endproperty
   a_win_tol: assert property (p_win_tol) else $error("window flag outside tolerance");
   property p_cur_lim;
      (!i_lim_neg_ok)[*5] |-> o_current_cmd == 0;
   endproperty
   a_cur_lim: assert property (p_cur_lim) else $error("current without travel permission");
   property p_start_speed;
      $rose(o_homing_busy) |=> o_speed_cmd == 16'sh0bb8 || o_speed_cmd == -16'sh0bb8;
   endproperty
   a_start_speed: assert property (p_start_speed) else $error("approach speed wrong");
   property p_speed_idle;
      o_speed_cmd != 0 |-> o_homing_busy || $past(o_homing_busy);
   endproperty
   a_speed_idle: assert property (p_speed_idle) else $error("speed outside homing");
   property p_done_zero;
      $rose(o_homing_done) |-> o_pos_actual == 0;
   endproperty
   a_done_zero: assert property (p_done_zero) else $error("zero not set at homing end");
   cover property ($rose(o_homing_done));
   cover property ($rose(o_in_window));
   cover property (o_par_rvalid);
endmodule

bind sprr_top sprr_properties chk_u (.i_clk, .i_arst_n, .i_ena, .i_go, .i_lim_neg_ok, .o_pos_error,
   .o_pos_actual, .o_in_window, .o_current_cmd, .o_speed_cmd, .o_homing_busy, .o_homing_done, .o_par_rvalid);
`default_nettype wire

//--- verif/sprr_axis_model.sv
`timescale 1ns/100ps
`default_nettype none
module sprr_axis_model #(
   parameter int SW_LO = 37
) (
   input  wire logic               i_clk,
   input  wire logic signed [15:0] i_speed,
   output logic                    o_step = 1'b0,
   output logic                    o_dir  = 1'b0,
   output logic                    o_zero = 1'b1,
   output logic                    o_sw   = 1'b0
);
   // ****************************************************************
   // axis with encoder and a narrow reference cam
   // ****************************************************************
   int pos = 0;
   int ph  = 0;
   // one step per four cycles at any nonzero speed; zero follows step by a cycle
   always @(posedge i_clk) begin
      ph <= (ph + 1) % 4;
      if (ph == 0 && i_speed != 0) begin
         o_step <= 1'b1;
         o_dir  <= i_speed < 0;
         pos    <= pos + ((i_speed < 0) ? -1 : 1);
      end
      if (ph == 1)
         o_zero <= (pos % 16 == 0);
      if (ph == 2)
         o_step <= 1'b0;
      o_sw <= (pos >= SW_LO) && (pos <= SW_LO + 8);
   end
endmodule
`default_nettype wire

//--- verif/tb_servo_position_reference_run.sv
`timescale 1ns/100ps
`default_nettype none
module tb_servo_position_reference_run
   import sprr_pkg::*;
();
   logic               clk = 0, arst_n = 0, ena = 0, go = 0, lneg = 1, digital_in_one = 0, digital_in_two = 0, tload = 0;
   logic signed [31:0] tgt = 0, perr, pact;
   sprr_par_req_t      par = '0;
   wire logic          step, dir, zero, sw;
   logic [15:0]        rdata, dect;
   logic signed [15:0] cur, spd;
   logic               rvalid, win, busy, done;
   int                 errors = 0, checks_done = 0;

   initial forever #2 clk = ~clk;

   sprr_axis_model axis_u (.i_clk(clk), .i_speed(spd), .o_step(step), .o_dir(dir), .o_zero(zero), .o_sw(sw));
   sprr_top #(.SETTLE_CYCLES(20)) dut_u (
      .i_clk(clk), .i_arst_n(arst_n), .i_ena(ena), .i_go(go), .i_lim_pos_ok(1'b1), .i_lim_neg_ok(lneg),
      .i_ref_switch(sw), .i_digital_in_one(digital_in_one), .i_digital_in_two(digital_in_two), .i_enc_step(step),
      .i_enc_dir(dir), .i_enc_zero(zero), .i_resolver_angle(16'h0aac), .i_pos_target(tgt),
      .i_target_load(tload), .i_par(par), .o_par_rdata(rdata), .o_par_rvalid(rvalid), .o_pos_error(perr),
      .o_pos_actual(pact), .o_in_window(win), .o_current_cmd(cur), .o_speed_cmd(spd), .o_decel_time_ms(dect),
      .o_homing_busy(busy), .o_homing_done(done));

   // ****************************************************************
   // access tasks
   // ****************************************************************
   task tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      par = {1'b1, 1'b0, a, d};
      tick();
      par = '0;
      tick();
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      par = {1'b0, 1'b1, a, 16'h0000};
      tick();
      par = '0;
      chk(rvalid, 1'b1);
      chk(rdata, e);
      tick();
   endtask
   task end_sim;
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // bounded so a stuck sequencer ends the run instead of hanging
   task wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         tick();
         n++;
      end
      if (n == 20000) begin
         errors++;
         end_sim();
      end
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      tick(20);
      arst_n = 1;
      tick();
      rd(ID_POSITION_GAIN, RST_POSITION_GAIN);
      rd(ID_HOMING_APPROACH, RST_HOMING_APPROACH);
      rd(ID_HOMING_RETURN, RST_HOMING_RETURN);
      rd(ID_TOL_WINDOW, RST_TOL_WINDOW);
      rd(8'h00, 16'h0000);
      wr(ID_RESOLVER_ZERO_CORR, 16'h0abc);
      rd(ID_RESOLVER_ZERO_CORR, 16'h0abc);
      wr(ID_RAMP_LIMIT_DECEL, 16'h1234);
      wr(ID_RAMP_ACCEL_TIME, 16'h0007);
      wr(ID_HOMING_CONFIG, 16'h0006);
      chk(dect, 16'h1234);
      wr(ID_HOMING_CONFIG, 16'h0002);
      chk(dect, 16'h0007);
      // a zero accel ramp keeps the homing reversal short
      wr(ID_RAMP_ACCEL_TIME, 16'h0000);
      rd(ID_RAMP_ACCEL_TIME, 16'h0000);
      wr(ID_HOMING_START, 16'h0001);
      chk(busy, 1'b0);
      tgt = 32'h0000_0100;
      ena = 1;
      go = 1;
      // a start edge inside the settle window must be ignored
      digital_in_one = 1;
      tick(5);
      wr(ID_HOMING_START, 16'h0001);
      chk(busy, 1'b0);
      chk(perr, 32'h0000_0100);
      chk(win, 1'b0);
      tick(30);
      chk(cur, 32'h0000_0046);
      lneg = 0;
      tick(6);
      chk(cur, 32'h0000_0000);
      lneg = 1;
      wr(ID_POSITION_GAIN, 16'h0000);
      tick(3);
      chk(cur, 32'h0000_0000);
      wr(ID_POSITION_GAIN, RST_POSITION_GAIN);
      tgt = 32'h0000_0020;
      tload = 1;
      tick();
      tload = 0;
      tick(4);
      chk(perr, 32'h0000_0020);
      chk(win, 1'b1);
      chk(cur, 32'h0000_0008);
      wr(ID_HOMING_START, 16'h0001);
      chk(busy, 1'b1);
      chk(spd, 32'h0000_0bb8);
      wait_done();
      chk(pact, 32'h0000_0000);
      // resolver run: offset plus angle minus correction lands on zero
      wr(ID_ZERO_OFFSET, 16'h0010);
      wr(ID_HOMING_CONFIG, 16'h000a);
      digital_in_two = 1;
      tick(4);
      chk(busy, 1'b1);
      chk(done, 1'b0);
      wait_done();
      rd(ID_ZERO_CAPTURE, 16'h0aac);
      chk(pact, 32'h0000_0000);
      wr(ID_HOMING_START, 16'h0001);
      chk(busy, 1'b1);
      go = 0;
      tick(6);
      chk(busy, 1'b0);
      chk(spd, 32'h0000_0000);
      chk(win, 1'b0);
      digital_in_one = 0;
      ena = 0;
      tick(12);
      end_sim();
   end
endmodule
`default_nettype wire
